// File: hw/adc_mode_gain_power_ctrl.sv
// Contract
// - Any gain pin high selects pin mode, all low selects register mode
// - Pin mode takes gain, power-down, reference and calibration from pins
// - Codes 0001 to 0111 give gains 1,2,3,4,6,8,12
// - Codes 1000 to 1110 give gains 16 to 128, bit3 leading
// - All gain pins low: gain comes from the control register field
// - Power-down code from register or from pins, by mode
// - Codes 000 off, 001 converters, 010 fast pair, 011 low-power pair
// - Code 100 all comparators, 101 everything on
// - Code 111 all off; in pin mode it also resets the device
// - Device reset clears registers and powers every unit down
// - Power-up sets every internal register to zero
// - Register mode starts powered down with gain 1 until a write
// - Control bits 6..4 power-down code, bits 3..0 gain code
// - Control bit 7 starts offset calibration
//
// Purpose: Mode, gain and power-down selection of a dual converter
// Assumes: Pins synchronous to clock; classic Wishbone register access
// Notes: Status reports readiness once the power-up time has elapsed
`timescale 1ns/10ps
`default_nettype none
module adc_mode_gain_power_ctrl
   import cfg_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Configuration pins
   input wire logic gain_select_bit3,
   input wire logic gain_select_bit2,
   input wire logic gain_select_bit1,
   input wire logic gain_select_bit0,
   input wire logic powerdown_sel_bit2,
   input wire logic powerdown_sel_bit1,
   input wire logic powerdown_sel_bit0,
   input wire logic reference_choice_pin,
   input wire logic cal_pin,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Analog control outputs
   output logic [3:0] pga_gain,
   output logic [7:0] gain_value,
   output logic lowp_cmp_on,
   output logic fast_cmp_on,
   output logic adc_on,
   output logic int_ref_sel,
   output logic cal_start,
   output logic pin_mode,
   output logic powered_up
);

   typedef struct packed {
      mode_e mode;
      logic pins_valid;
      logic [3:0] gain_pins;
      logic [2:0] pd_pins;
      logic ref_pin;
      logic cal_pin;
      logic [11:0] ctrl;
      logic [3:0] gain;
      logic [2:0] pd;
      logic cal;
      logic int_ref;
      logic [13:0] up_cnt;
      logic ready;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   logic wb_req;
   logic [3:0] sel_gain;
   logic [2:0] sel_pd;
   logic sel_cal;
   logic pin_reset;
   logic [13:0] up_target;

   assign wb_req = wb_cyc_i & wb_stb_i & ~st_r.ack & ~st_r.err;

   // Effective sources chosen from captured pins in pin mode, from the control register otherwise
   always_comb begin
      if (st_r.mode == ST_PIN) begin
         sel_gain = st_r.gain_pins;
         sel_pd = st_r.pd_pins;
         sel_cal = st_r.cal_pin;
      end else begin
         sel_gain = st_r.ctrl[GAIN_MSB:GAIN_LSB];
         sel_pd = st_r.ctrl[PD_MSB:PD_LSB];
         sel_cal = st_r.ctrl[CAL_BIT];
      end
      pin_reset = (st_r.mode == ST_PIN) && (st_r.pd_pins == PD_RESET);
      up_target = st_r.int_ref ? 14'(TINT_CYC) : 14'(TEXT_CYC);
   end

   // Next state of the whole block
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      // Pins captured first, used a cycle later
      st_nxt.gain_pins = {gain_select_bit3, gain_select_bit2,
                          gain_select_bit1, gain_select_bit0};
      st_nxt.pd_pins = {powerdown_sel_bit2, powerdown_sel_bit1,
                        powerdown_sel_bit0};
      st_nxt.ref_pin = reference_choice_pin;
      st_nxt.cal_pin = cal_pin;
      unique case (st_r.mode)
         ST_BOOT: begin
            st_nxt.up_cnt = '0;
            if (!st_r.pins_valid) begin
               // Capture register still holds its reset zeros
               st_nxt.pins_valid = 1'b1;
            end else begin
               // Mode decided once from pins seen at power-up
               st_nxt.int_ref = st_r.ref_pin;
               if (st_r.gain_pins != GAIN_SW) begin
                  st_nxt.mode = ST_PIN;
               end else begin
                  st_nxt.mode = ST_REG;
               end
            end
         end
         ST_REG, ST_PIN: begin
            if (!st_r.ready) begin
               if (st_r.up_cnt >= up_target - 14'd1) begin
                  st_nxt.ready = 1'b1;
               end else begin
                  st_nxt.up_cnt = st_r.up_cnt + 14'd1;
               end
            end
            // Reserved gain code keeps the applied gain
            if (sel_gain != GAIN_RSVD && sel_gain != GAIN_SW) begin
               st_nxt.gain = sel_gain;
            end else if (sel_gain == GAIN_SW) begin
               st_nxt.gain = GAIN_DEFAULT;
            end
            st_nxt.pd = sel_pd;
            st_nxt.cal = sel_cal;
         end
         default: st_nxt.mode = ST_BOOT;
      endcase
      // Register access, one wait-state ack
      if (wb_req) begin
         unique case (wb_adr_i)
            CTRL_OFS: begin
               st_nxt.ack = 1'b1;
               st_nxt.rdata = {20'h0_0000, st_r.ctrl};
               if (wb_we_i) begin
                  if (wb_sel_i[0]) begin
                     st_nxt.ctrl[7:0] = wb_dat_i[7:0];
                  end
                  if (wb_sel_i[1]) begin
                     st_nxt.ctrl[11:8] = wb_dat_i[11:8];
                  end
               end
            end
            STAT_OFS: begin
               st_nxt.ack = 1'b1;
               st_nxt.rdata = {24'h00_0000, st_r.ready, st_r.int_ref,
                               st_r.mode == ST_PIN, st_r.cal, 1'b0,
                               st_r.pd};
            end
            GAIN_OFS: begin
               st_nxt.ack = 1'b1;
               st_nxt.rdata = {28'h000_0000, st_r.gain};
            end
            default: begin
               st_nxt.err = 1'b1;
               st_nxt.rdata = '0;
            end
         endcase
      end
      // Pin-mode reset code clears control, gain, power-down and calibration registers
      if (pin_reset) begin
         st_nxt.ctrl = CTRL_RESET;
         st_nxt.gain = GAIN_SW;
         st_nxt.pd = PD_ALL_OFF;
         st_nxt.cal = 1'b0;
      end
   end

   // State register, all zero after reset
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Gain code to integer gain
   always_comb begin
      unique case (st_r.gain)
         4'h1: gain_value = 8'h01;
         4'h2: gain_value = 8'h02;
         4'h3: gain_value = 8'h03;
         4'h4: gain_value = 8'h04;
         4'h5: gain_value = 8'h06;
         4'h6: gain_value = 8'h08;
         4'h7: gain_value = 8'h0C;
         4'h8: gain_value = 8'h10;
         4'h9: gain_value = 8'h18;
         4'hA: gain_value = 8'h20;
         4'hB: gain_value = 8'h30;
         4'hC: gain_value = 8'h40;
         4'hD: gain_value = 8'h60;
         4'hE: gain_value = 8'h80;
         default: gain_value = 8'h00;
      endcase
   end

   // Power-down decode; boot state keeps everything off
   always_comb begin
      lowp_cmp_on = 1'b0;
      fast_cmp_on = 1'b0;
      adc_on = 1'b0;
      unique case (st_r.pd)
         PD_ADC_ONLY: adc_on = 1'b1;
         PD_FAST_ONLY: fast_cmp_on = 1'b1;
         PD_LOWP_ONLY: lowp_cmp_on = 1'b1;
         PD_CMP_ALL: begin
            lowp_cmp_on = 1'b1;
            fast_cmp_on = 1'b1;
         end
         PD_ALL_ON: begin
            lowp_cmp_on = 1'b1;
            fast_cmp_on = 1'b1;
            adc_on = 1'b1;
         end
         default: ; // Codes 000, 110, 111 all off
      endcase
   end

   assign pga_gain = st_r.gain;
   assign int_ref_sel = st_r.int_ref;
   assign cal_start = st_r.cal;
   assign pin_mode = (st_r.mode == ST_PIN);
   assign powered_up = st_r.ready;
   assign wb_dat_o = st_r.rdata;
   assign wb_ack_o = st_r.ack;
   assign wb_err_o = st_r.err;

   // Mode is chosen once, from pins captured after reset
   chk_mode_from_pins: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_BOOT && st_r.pins_valid
      |=> (st_r.mode == ST_PIN) == $past(st_r.gain_pins != 4'h0))
      else $error("mode not chosen from pins");
   chk_mode_held: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode != ST_BOOT |=> $stable(st_r.mode))
      else $error("mode changed after boot");

   // Pin-mode sources, one clock behind the captured pins
   chk_pin_gain_follow: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_PIN && !pin_reset && st_r.gain_pins != 4'hF
      && st_r.gain_pins != 4'h0 |=> pga_gain == $past(st_r.gain_pins))
      else $error("pin gain not applied");
   chk_pin_pd_source: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_PIN && !pin_reset |=> st_r.pd == $past(st_r.pd_pins))
      else $error("pin power-down not applied");
   chk_pin_cal_follow: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_PIN && !pin_reset |=> cal_start == $past(st_r.cal_pin))
      else $error("pin calibration not applied");
   chk_rsvd_gain_keep: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_PIN && st_r.gain_pins == 4'hF && !pin_reset
      |=> $stable(pga_gain))
      else $error("reserved gain changed gain");

   // Register-mode sources, one clock behind the control register
   chk_reg_gain_field: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_REG && st_r.ctrl[3:0] inside {[4'h1:4'hE]}
      |=> pga_gain == $past(st_r.ctrl[3:0]))
      else $error("register gain not applied");
   chk_reg_default_gain: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_REG && st_r.ctrl[3:0] == 4'h0 |=> pga_gain == 4'h1)
      else $error("default gain not one");
   chk_rsvd_reg_keep: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_REG && st_r.ctrl[3:0] == 4'hF |=> $stable(pga_gain))
      else $error("reserved register gain changed gain");
   chk_reg_pd_field: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_REG |=> st_r.pd == $past(st_r.ctrl[6:4]))
      else $error("register power-down not applied");
   chk_reg_cal_bit: assert property (
      @(posedge clock) disable iff (rst)
      st_r.mode == ST_REG && !pin_reset |=> cal_start == $past(st_r.ctrl[7]))
      else $error("calibration bit not applied");

   // Power-down decode, one code at a time
   chk_adc_only_code: assert property (
      @(posedge clock) disable iff (rst) st_r.pd == PD_ADC_ONLY
      |-> adc_on && !lowp_cmp_on && !fast_cmp_on)
      else $error("code 001 decode wrong");
   chk_fast_only_code: assert property (
      @(posedge clock) disable iff (rst) st_r.pd == PD_FAST_ONLY
      |-> fast_cmp_on && !lowp_cmp_on && !adc_on)
      else $error("code 010 decode wrong");
   chk_lowp_only_code: assert property (
      @(posedge clock) disable iff (rst) st_r.pd == PD_LOWP_ONLY
      |-> lowp_cmp_on && !fast_cmp_on && !adc_on)
      else $error("code 011 decode wrong");
   chk_cmp_all_code: assert property (
      @(posedge clock) disable iff (rst) st_r.pd == PD_CMP_ALL
      |-> lowp_cmp_on && fast_cmp_on && !adc_on)
      else $error("code 100 decode wrong");
   chk_full_power_on: assert property (
      @(posedge clock) disable iff (rst) st_r.pd == PD_ALL_ON
      |-> lowp_cmp_on && fast_cmp_on && adc_on)
      else $error("code 101 not fully on");

   // Both kinds of reset leave control and gain clear, calibration and units off
   chk_pin_reset_clear: assert property (
      @(posedge clock) disable iff (rst)
      pin_reset |=> st_r.ctrl == 12'h000 && !adc_on && !fast_cmp_on)
      else $error("pin reset did not clear");
   chk_pin_reset_gain: assert property (
      @(posedge clock) disable iff (rst)
      pin_reset |=> pga_gain == 4'h0 && !lowp_cmp_on && !cal_start)
      else $error("pin reset left gain or units set");
   chk_reset_zero: assert property (
      @(posedge clock)
      rst |=> st_r.ctrl == 12'h000 && pga_gain == 4'h0 && !adc_on)
      else $error("reset did not zero state");
   chk_reset_powered_down: assert property (
      @(posedge clock) rst
      |=> !lowp_cmp_on && !fast_cmp_on && !cal_start && !powered_up)
      else $error("reset left a unit on");

endmodule
`default_nettype wire

// File: common/cfg_pkg.sv
// Purpose: Constants for the converter mode, gain and power control block
// Assumes: Classic Wishbone slave, 32-bit data, 40 MHz clock
// Notes: Register offsets are byte addresses
package cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] GAIN_OFS = 8'h08;
   // Control register fields
   localparam int CAL_BIT = 7;
   localparam int PD_MSB = 6;
   localparam int PD_LSB = 4;
   localparam int GAIN_MSB = 3;
   localparam int GAIN_LSB = 0;
   localparam logic [11:0] CTRL_RESET = 12'h000;
   // Gain codes
   localparam logic [3:0] GAIN_SW = 4'h0;
   localparam logic [3:0] GAIN_RSVD = 4'hF;
   localparam logic [3:0] GAIN_DEFAULT = 4'h1;
   // Power-down codes
   localparam logic [2:0] PD_ALL_OFF = 3'h0;
   localparam logic [2:0] PD_ADC_ONLY = 3'h1;
   localparam logic [2:0] PD_FAST_ONLY = 3'h2;
   localparam logic [2:0] PD_LOWP_ONLY = 3'h3;
   localparam logic [2:0] PD_CMP_ALL = 3'h4;
   localparam logic [2:0] PD_ALL_ON = 3'h5;
   localparam logic [2:0] PD_RESET = 3'h7;
   // Power-up times
   localparam int CLK_MHZ = 40;
   localparam int TEXT_US = 15;
   localparam int TINT_US = 240;
   localparam int TEXT_CYC = TEXT_US * CLK_MHZ;
   localparam int TINT_CYC = TINT_US * CLK_MHZ;
   // Mode states
   typedef enum logic [1:0] {
      ST_BOOT = 2'b00,
      ST_REG = 2'b01,
      ST_PIN = 2'b10
   } mode_e;
endpackage

// File: bench/host_pin_model.sv
// Purpose: Host side that drives the configuration pins
// Assumes: Host logic updates pins one clock after a command
// Notes: Pins are static levels, so no idle pattern applies
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
   // Clock
   input wire logic clock,
   // Commanded levels
   input wire logic [3:0] gain_code,
   input wire logic [2:0] pd_code,
   input wire logic ref_in,
   input wire logic cal_in,
   // Pins
   output var logic gain_select_bit3,
   output var logic gain_select_bit2,
   output var logic gain_select_bit1,
   output var logic gain_select_bit0,
   output var logic powerdown_sel_bit2,
   output var logic powerdown_sel_bit1,
   output var logic powerdown_sel_bit0,
   output var logic reference_choice_pin,
   output var logic cal_pin
);
   // Host puts its levels on the pins, registered like board logic
   always_ff @(posedge clock) begin
      {gain_select_bit3, gain_select_bit2} <= gain_code[3:2];
      {gain_select_bit1, gain_select_bit0} <= gain_code[1:0];
      {powerdown_sel_bit2, powerdown_sel_bit1} <= pd_code[2:1];
      powerdown_sel_bit0 <= pd_code[0];
      reference_choice_pin <= ref_in;
      cal_pin <= cal_in;
   end
endmodule
`default_nettype wire

// File: bench/tb_adc_mode_gain_power_ctrl.sv
// Purpose: Self-checking bench for mode, gain and power control
// Assumes: Classic Wishbone answer within a few cycles
// Notes: Pin mode is only re-evaluated through rst
`timescale 1ns/10ps
`default_nettype none
module tb_adc_mode_gain_power_ctrl
   import cfg_pkg::*;
   ;
   logic clock = 0, rst = 1, cal_start, pin_mode, powered_up;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o;
   logic [7:0] wb_adr_i = 8'h00, gain_value;
   logic [3:0] wb_sel_i = 4'h0, pga_gain, gcmd = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   logic [2:0] pcmd = 3'h0;
   logic refc = 0, calc = 0, e, lowp_cmp_on, fast_cmp_on, adc_on, int_ref_sel;
   wire logic gain_select_bit3, gain_select_bit2, gain_select_bit1;
   wire logic gain_select_bit0, powerdown_sel_bit2, powerdown_sel_bit1;
   wire logic powerdown_sel_bit0, reference_choice_pin, cal_pin;
   int n_errors = 0, n_tests = 0;
   // Expected gain per code and {low-power, fast, converters} per pd code
   localparam logic [7:0] GTAB [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
      8'h06, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80,
      8'h00};
   localparam logic [2:0] PTAB [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7,
      3'h0, 3'h0};
   // 40 MHz clock
   always #12.5 clock = ~clock;
   host_pin_model host_u (.clock, .gain_code(gcmd), .pd_code(pcmd),
      .ref_in(refc), .cal_in(calc), .gain_select_bit3, .gain_select_bit2,
      .gain_select_bit1, .gain_select_bit0, .powerdown_sel_bit2,
      .powerdown_sel_bit1, .powerdown_sel_bit0, .reference_choice_pin,
      .cal_pin);
   adc_mode_gain_power_ctrl dut_u (.clock, .rst, .gain_select_bit3,
      .gain_select_bit2, .gain_select_bit1, .gain_select_bit0,
      .powerdown_sel_bit2, .powerdown_sel_bit1, .powerdown_sel_bit0,
      .reference_choice_pin, .cal_pin, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
      .pga_gain, .gain_value, .lowp_cmp_on, .fast_cmp_on, .adc_on,
      .int_ref_sel, .cal_start, .pin_mode, .powered_up);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One classic cycle; holds the request until ack or err is sampled
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int i;
      @(posedge clock);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hF};
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && i < 50);
      q = wb_dat_o;
      e = wb_err_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (i >= 50) n_errors++;
   endtask
   // Reset with pin levels settled, so the boot capture sees them
   task automatic do_reset(input logic [3:0] g, input logic [2:0] p,
         input logic r);
      {gcmd, pcmd, refc, rst} <= {g, p, r, 1'b1};
      wt(3);
      check(pga_gain, 4'h0);
      rst <= 0;
      wt(6);
   endtask
   task automatic complete_run;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 10600 cycles
   initial begin
      wt(40000);
      n_errors++;
      complete_run();
   end
   initial begin
      do_reset(4'h0, 3'h0, 1'b0);
      check(pin_mode, 1'b0);
      check({lowp_cmp_on, fast_cmp_on, adc_on}, 3'h0);
      check(pga_gain, GAIN_DEFAULT);
      check(powered_up, 1'b0);
      wb(0, CTRL_OFS, 0);
      check(q, 32'h0000_0000);
      for (int c = 1; c < 15; c++) begin
         wb(1, CTRL_OFS, 32'(c));
         wt(3);
         check(gain_value, GTAB[c]);
      end
      wb(1, CTRL_OFS, 32'h0000_000F);
      wt(3);
      check(gain_value, 8'h80);
      for (int p = 0; p < 8; p++) begin
         wb(1, CTRL_OFS, 32'(p * 16 + 2));
         wt(3);
         check({lowp_cmp_on, fast_cmp_on, adc_on}, PTAB[p]);
      end
      wb(0, CTRL_OFS, 0);
      check(q, 32'h0000_0072);
      wb(1, CTRL_OFS, 32'h0000_00D1);
      wt(3);
      check(cal_start, 1'b1);
      wb(0, 8'h0C, 0);
      check(e, 1'b1);
      wt(700);
      check(powered_up, 1'b1);
      wb(0, STAT_OFS, 0);
      check(q, 32'h0000_0095);
      wb(0, GAIN_OFS, 0);
      check(q, 32'h0000_0001);
      $display("register mode test done");
      do_reset(4'h2, 3'h5, 1'b1);
      check(pin_mode, 1'b1);
      check(int_ref_sel, 1'b1);
      for (int c = 1; c < 16; c++) begin
         gcmd <= c[3:0];
         wt(6);
         check(gain_value, c < 15 ? GTAB[c] : 8'h80);
      end
      for (int p = 0; p < 7; p++) begin
         pcmd <= p[2:0];
         wt(6);
         check({lowp_cmp_on, fast_cmp_on, adc_on}, PTAB[p]);
      end
      wb(1, CTRL_OFS, 32'h0000_0055);
      calc <= 1;
      wt(6);
      check(cal_start, 1'b1);
      {pcmd, calc} <= {3'h7, 1'b0};
      wt(6);
      check(pga_gain, 4'h0);
      wb(0, CTRL_OFS, 0);
      check(q, 32'h0000_0000);
      {pcmd, gcmd} <= {3'h5, 4'h3};
      wt(6);
      check({gain_value, 7'h00, adc_on}, 16'h0301);
      check(powered_up, 1'b0);
      wt(9600);
      check(powered_up, 1'b1);
      wb(0, STAT_OFS, 0);
      check(q, 32'h0000_00E5);
      $display("pin mode test done");
      complete_run();
   end
endmodule
`default_nettype wire
